// *** hdl/fsl_pkg.sv ***
// Notes on behaviour
// - fast strobe asserted clock after frame
// - over three strobe clocks commits, else abort
// - abort on foreign claim, except companion config
// - abort: io above 64K, far memory, retry
// - unclaimed isa abort gives master abort
// - no strobe while dma owns and buffer busy
// - isa space decode from five sources
// - address hold from confirm to ready/turnaround
// - cpu writes to isa space never posted
// - wait one slow strobe clock, writes idle
// - read latches one word or two words
// - turnaround, high addr, command, low addr
// - write data words follow low address
// - byte enables low nibble, command next nibble
// - ninth bit carries delayed initiator ready
// - low host address lines hold original address
// - ready copy, command, enables on upper lines
package fsl_pkg;
  localparam int ADDR_W = 32;
  localparam int LINK_W = 16;
  localparam int LOW_W = 14;
  localparam int BE_LSB = 0;
  localparam int CMD_LSB = 4;
  localparam int IRDY_BIT = 8;
  localparam int IO_TOP_LSB = 16;
  localparam int MEM_TOP_LSB = 24;
  localparam int LOW_ADDR_LSB = 2;
  localparam logic [LINK_W-1:0] BUS_IDLE = 16'hffff;
  localparam logic [LINK_W-1:0] CMD_WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] WORD_RST = 32'h0000_0000;

  typedef enum logic [9:0] {
    F_IDLE = 10'h001,
    F_TA   = 10'h002,
    F_HI   = 10'h004,
    F_CMD  = 10'h008,
    F_LO   = 10'h010,
    F_DLO  = 10'h020,
    F_DHI  = 10'h040,
    F_TA2  = 10'h080,
    F_WAIT = 10'h100,
    F_RHI  = 10'h200
  } fsl_fast_state_type;

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_HI   = 10'h002,
    S_CMD  = 10'h004,
    S_LO   = 10'h008,
    S_D0   = 10'h010,
    S_D1   = 10'h020,
    S_TA   = 10'h040,
    S_WAIT = 10'h080,
    S_ACK  = 10'h100,
    S_RHI  = 10'h200
  } fsl_slow_state_type;
endpackage

// *** hdl/fsl_link_if.sv ***
`timescale 1ns/10ps
interface fsl_link_if;
  logic fast_start_ready_strobe_n;
  logic slow_start_ready_strobe_n;
  logic [fsl_pkg::LINK_W-1:0] fast_ha_out;
  logic fast_ha_oe;
  logic [fsl_pkg::LINK_W-1:0] slow_ha_out;
  logic slow_ha_oe;
  logic [fsl_pkg::LOW_W-1:0] host_address_low;
  logic [fsl_pkg::LINK_W-1:0] shared_host_address_upper;

  // released lines float high through the board pull-ups
  assign shared_host_address_upper = fast_ha_oe ? fast_ha_out :
                                     slow_ha_oe ? slow_ha_out : fsl_pkg::BUS_IDLE;

  modport fast (
    output fast_start_ready_strobe_n, fast_ha_out, fast_ha_oe, host_address_low,
    input slow_start_ready_strobe_n, shared_host_address_upper
  );
  modport slow (
    output slow_start_ready_strobe_n, slow_ha_out, slow_ha_oe,
    input fast_start_ready_strobe_n, shared_host_address_upper, host_address_low
  );
endinterface

// *** hdl/fsl_fast_end.sv ***
`timescale 1ns/10ps
module fsl_fast_end (
  input wire logic clk_in, // pci clock
  input wire logic rstn_in, // async reset, low
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic req_valid_in, // frame seen for an isa-bound cycle
  output logic req_ready_out, // request may be taken
  input wire logic req_cpu_in, // request comes from the cpu
  input wire logic req_write_in, // 1 = write
  input wire logic req_dword_in, // read returns two words
  input wire logic [31:0] req_addr_in, // cycle address
  input wire logic [3:0] req_cmd_in, // pci command
  input wire logic [3:0] req_be_in, // byte enables, low active
  input wire logic [31:0] req_wdata_in, // write data
  input wire logic req_irdy_dly_in, // delayed initiator ready, 0 = data sent
  input wire logic req_mem_in, // 1 = memory, 0 = i/o
  input wire logic isa_hole_in, // address in isa memory hole
  input wire logic bios_noshadow_in, // unshadowed bios area
  input wire logic rom_cd_in, // c/d rom segment below 1M
  input wire logic vram_ab_fwd_in, // a/b video ram forwarded to isa
  input wire logic onboard_in, // onboard memory or local bus device
  input wire logic other_claim_in, // another pci agent decoded
  input wire logic cfg_space_in, // companion configuration access
  input wire logic retry_in, // target logic retries the access
  input wire logic dma_owner_in, // isa/dma master owns the cycle
  input wire logic pwb_busy_in, // post-write buffer busy
  output logic post_allow_out, // write of presented request may be posted
  output logic busy_out, // link cycle in progress
  output logic ahold_out, // cpu address hold
  output logic done_out, // target ready pulse, cycle complete
  output logic abort_out, // link cycle aborted pulse
  output logic master_abort_out, // end pci cycle with master abort, pulse
  output logic [31:0] rdata_out, // latched read data
  fsl_link_if.fast link // link to companion controller
);

  // ****************************************
  // request decode
  // ****************************************
  fsl_pkg::fsl_fast_state_type st_r;
  fsl_pkg::fsl_fast_state_type st_nxt;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [3:0] cmd_r;
  logic [3:0] be_r;
  logic wr_r;
  logic dword_r;
  logic irdy_dly_r;
  logic far_r;
  logic isa_space;
  logic far_addr;
  logic take;
  logic window;
  logic claim_abort;
  logic isa_abort;
  logic abort_now;
  logic slow_seen;

  assign isa_space = !req_mem_in | isa_hole_in | bios_noshadow_in | rom_cd_in | vram_ab_fwd_in;
  assign far_addr = (!req_mem_in & (|req_addr_in[31:fsl_pkg::IO_TOP_LSB])) |
                    (req_mem_in & (|req_addr_in[31:fsl_pkg::MEM_TOP_LSB]) & !isa_space);
  // posting a cpu isa write would let cpu and link fight over the host address bus
  assign post_allow_out = !(req_cpu_in & isa_space);
  assign req_ready_out = (st_r == fsl_pkg::F_IDLE) & !(dma_owner_in & pwb_busy_in);
  assign take = req_valid_in & req_ready_out;
  assign busy_out = (st_r != fsl_pkg::F_IDLE);

  // ****************************************
  // abort window
  // ****************************************
  // strobe low in ta, hi and cmd: leaving before lo keeps it to three clocks
  assign window = (st_r == fsl_pkg::F_TA) | (st_r == fsl_pkg::F_HI) | (st_r == fsl_pkg::F_CMD);
  assign claim_abort = other_claim_in & !cfg_space_in;
  assign isa_abort = far_r | retry_in;
  assign abort_now = window & (claim_abort | isa_abort);
  assign slow_seen = !link.slow_start_ready_strobe_n;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      fsl_pkg::F_IDLE: begin
        if (take) begin
          st_nxt = fsl_pkg::F_TA;
        end
      end
      fsl_pkg::F_TA: st_nxt = abort_now ? fsl_pkg::F_IDLE : fsl_pkg::F_HI;
      fsl_pkg::F_HI: st_nxt = abort_now ? fsl_pkg::F_IDLE : fsl_pkg::F_CMD;
      fsl_pkg::F_CMD: st_nxt = abort_now ? fsl_pkg::F_IDLE : fsl_pkg::F_LO;
      fsl_pkg::F_LO: begin
        if (wr_r & !irdy_dly_r) begin
          st_nxt = fsl_pkg::F_DLO;
        end else begin
          st_nxt = fsl_pkg::F_TA2;
        end
      end
      fsl_pkg::F_DLO: st_nxt = fsl_pkg::F_DHI;
      fsl_pkg::F_DHI: st_nxt = fsl_pkg::F_TA2;
      fsl_pkg::F_TA2: st_nxt = fsl_pkg::F_WAIT;
      fsl_pkg::F_WAIT: begin
        if (slow_seen) begin
          st_nxt = (!wr_r & dword_r) ? fsl_pkg::F_RHI : fsl_pkg::F_IDLE;
        end
      end
      fsl_pkg::F_RHI: st_nxt = fsl_pkg::F_IDLE;
      default: st_nxt = fsl_pkg::F_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= fsl_pkg::F_IDLE;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_r <= fsl_pkg::WORD_RST;
      wdata_r <= fsl_pkg::WORD_RST;
      cmd_r <= 4'h0;
      be_r <= 4'hf;
      wr_r <= 1'b0;
      dword_r <= 1'b0;
      irdy_dly_r <= 1'b1;
      far_r <= 1'b0;
    end else if (ce_in && take) begin
      addr_r <= req_addr_in;
      wdata_r <= req_wdata_in;
      cmd_r <= req_cmd_in;
      be_r <= req_be_in;
      wr_r <= req_write_in;
      dword_r <= req_dword_in;
      irdy_dly_r <= req_irdy_dly_in;
      far_r <= far_addr;
    end
  end

  // ****************************************
  // read data and completion
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= fsl_pkg::WORD_RST;
    end else if (ce_in) begin
      if (st_r == fsl_pkg::F_WAIT && slow_seen && !wr_r) begin
        rdata_out[15:0] <= link.shared_host_address_upper;
      end else if (st_r == fsl_pkg::F_RHI) begin
        rdata_out[31:16] <= link.shared_host_address_upper;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
      abort_out <= 1'b0;
      master_abort_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= (st_r != fsl_pkg::F_IDLE) & (st_nxt == fsl_pkg::F_IDLE) & !abort_now;
      abort_out <= abort_now;
      master_abort_out <= abort_now & isa_abort & !other_claim_in;
    end
  end

  // released at completion on reads, at turnaround on writes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ahold_out <= 1'b0;
    end else if (ce_in) begin
      if (take) begin
        ahold_out <= req_cpu_in & !onboard_in;
      end else if (abort_now || (st_nxt == fsl_pkg::F_IDLE)) begin
        ahold_out <= 1'b0;
      end else if (wr_r && st_nxt == fsl_pkg::F_TA2) begin
        ahold_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // link drive
  // ****************************************
  assign link.fast_start_ready_strobe_n = !(window | (st_r == fsl_pkg::F_LO));
  assign link.host_address_low = addr_r[15:fsl_pkg::LOW_ADDR_LSB];

  always_comb begin
    link.fast_ha_oe = 1'b1;
    link.fast_ha_out = fsl_pkg::BUS_IDLE;
    case (st_r)
      fsl_pkg::F_HI: link.fast_ha_out = addr_r[31:16];
      fsl_pkg::F_CMD: begin
        link.fast_ha_out = fsl_pkg::CMD_WORD_RST;
        link.fast_ha_out[fsl_pkg::BE_LSB +: 4] = be_r;
        link.fast_ha_out[fsl_pkg::CMD_LSB +: 4] = cmd_r;
        link.fast_ha_out[fsl_pkg::IRDY_BIT] = irdy_dly_r;
      end
      fsl_pkg::F_LO: link.fast_ha_out = addr_r[15:0];
      fsl_pkg::F_DLO: link.fast_ha_out = wdata_r[15:0];
      fsl_pkg::F_DHI: link.fast_ha_out = wdata_r[31:16];
      default: link.fast_ha_oe = 1'b0;
    endcase
  end

endmodule

// *** hdl/fsl_slow_end.sv ***
`timescale 1ns/10ps
module fsl_slow_end (
  input wire logic clk_in, // pci clock
  input wire logic rstn_in, // async reset, low
  input wire logic ce_in, // clock enable, freezes all state
  output logic cyc_valid_out, // committed link cycle pulse
  output logic [31:0] cyc_addr_out, // cycle address
  output logic [3:0] cyc_cmd_out, // pci command
  output logic [3:0] cyc_be_out, // byte enables
  output logic cyc_irdy_dly_out, // delayed initiator ready copy
  output logic [31:0] cyc_wdata_out, // write data
  output logic cyc_write_out, // 1 = write command
  output logic cyc_abort_out, // strobe dropped early, pulse
  input wire logic done_valid_in, // isa side finished
  output logic done_ready_out, // completion may be taken
  input wire logic done_dword_in, // return two read words
  input wire logic [31:0] done_rdata_in, // read data
  fsl_link_if.slow link // link to host bridge
);

  // ****************************************
  // capture
  // ****************************************
  fsl_pkg::fsl_slow_state_type st_r;
  fsl_pkg::fsl_slow_state_type st_nxt;
  logic [15:0] cmd_word_r;
  logic [31:0] rdata_r;
  logic dword_r;
  logic strobe;
  logic wr_cmd;
  logic take_done;
  logic [15:0] bus;

  assign strobe = !link.fast_start_ready_strobe_n;
  assign bus = link.shared_host_address_upper;
  assign wr_cmd = cmd_word_r[fsl_pkg::CMD_LSB];
  assign done_ready_out = (st_r == fsl_pkg::S_WAIT);
  assign take_done = done_valid_in & done_ready_out;
  assign cyc_cmd_out = cmd_word_r[fsl_pkg::CMD_LSB +: 4];
  assign cyc_be_out = cmd_word_r[fsl_pkg::BE_LSB +: 4];
  assign cyc_irdy_dly_out = cmd_word_r[fsl_pkg::IRDY_BIT];
  assign cyc_write_out = wr_cmd;

  // ****************************************
  // sequencer
  // ****************************************
  // idle sees the turnaround clock; fourth strobe clock is lo, where it commits
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      fsl_pkg::S_IDLE: st_nxt = strobe ? fsl_pkg::S_HI : fsl_pkg::S_IDLE;
      fsl_pkg::S_HI: st_nxt = strobe ? fsl_pkg::S_CMD : fsl_pkg::S_IDLE;
      fsl_pkg::S_CMD: st_nxt = strobe ? fsl_pkg::S_LO : fsl_pkg::S_IDLE;
      fsl_pkg::S_LO: begin
        if (!strobe) begin
          st_nxt = fsl_pkg::S_IDLE;
        end else if (wr_cmd && !cmd_word_r[fsl_pkg::IRDY_BIT]) begin
          st_nxt = fsl_pkg::S_D0;
        end else begin
          st_nxt = fsl_pkg::S_TA;
        end
      end
      fsl_pkg::S_D0: st_nxt = fsl_pkg::S_D1;
      fsl_pkg::S_D1: st_nxt = fsl_pkg::S_TA;
      fsl_pkg::S_TA: st_nxt = fsl_pkg::S_WAIT;
      fsl_pkg::S_WAIT: st_nxt = take_done ? fsl_pkg::S_ACK : fsl_pkg::S_WAIT;
      fsl_pkg::S_ACK: st_nxt = (!wr_cmd && dword_r) ? fsl_pkg::S_RHI : fsl_pkg::S_IDLE;
      fsl_pkg::S_RHI: st_nxt = fsl_pkg::S_IDLE;
      default: st_nxt = fsl_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= fsl_pkg::S_IDLE;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cyc_addr_out <= fsl_pkg::WORD_RST;
      cmd_word_r <= fsl_pkg::CMD_WORD_RST;
      cyc_wdata_out <= fsl_pkg::WORD_RST;
    end else if (ce_in) begin
      case (st_r)
        fsl_pkg::S_HI: cyc_addr_out[31:16] <= bus;
        fsl_pkg::S_CMD: cmd_word_r <= bus;
        fsl_pkg::S_LO: cyc_addr_out[15:0] <= bus;
        fsl_pkg::S_D0: cyc_wdata_out[15:0] <= bus;
        fsl_pkg::S_D1: cyc_wdata_out[31:16] <= bus;
        default: cyc_addr_out <= cyc_addr_out;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cyc_valid_out <= 1'b0;
      cyc_abort_out <= 1'b0;
    end else if (ce_in) begin
      cyc_valid_out <= (st_nxt == fsl_pkg::S_TA);
      // a drop seen in lo means the fourth strobe clock is missing, so that cycle aborts too
      cyc_abort_out <= !strobe &
                       ((st_r == fsl_pkg::S_HI) | (st_r == fsl_pkg::S_CMD) | (st_r == fsl_pkg::S_LO));
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= fsl_pkg::WORD_RST;
      dword_r <= 1'b0;
    end else if (ce_in && take_done) begin
      rdata_r <= done_rdata_in;
      dword_r <= done_dword_in;
    end
  end

  // ****************************************
  // link drive
  // ****************************************
  assign link.slow_start_ready_strobe_n = (st_r != fsl_pkg::S_ACK);

  // waiting keeps the upper address on the lines; some cards read them as latched address
  always_comb begin
    link.slow_ha_oe = 1'b1;
    link.slow_ha_out = fsl_pkg::BUS_IDLE;
    case (st_r)
      fsl_pkg::S_WAIT: link.slow_ha_out = cyc_addr_out[31:16];
      fsl_pkg::S_ACK: link.slow_ha_out = wr_cmd ? cyc_addr_out[31:16] : rdata_r[15:0];
      fsl_pkg::S_RHI: link.slow_ha_out = rdata_r[31:16];
      default: link.slow_ha_oe = 1'b0;
    endcase
  end

endmodule

// *** test/fsl_chk.sv ***
`timescale 1ns/10ps
module fsl_chk (
  input wire logic clk_in, // pci clock
  input wire logic rstn_in, // async reset, low
  input wire logic fast_start_ready_strobe_n, // fast strobe
  input wire logic slow_start_ready_strobe_n, // slow strobe
  input wire logic [fsl_pkg::LINK_W-1:0] fast_ha_out, // fast end drive
  input wire logic fast_ha_oe, // fast end enable
  input wire logic [fsl_pkg::LINK_W-1:0] slow_ha_out, // slow end drive
  input wire logic slow_ha_oe, // slow end enable
  input wire logic [fsl_pkg::LOW_W-1:0] host_address_low, // low address lines
  input wire logic [fsl_pkg::LINK_W-1:0] shared_host_address_upper // resolved upper lines
);
  // ********************************
  // link protocol checks
  // ********************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic f_n;
  logic s_n;
  assign f_n = fast_start_ready_strobe_n;
  assign s_n = slow_start_ready_strobe_n;

  a_strobe_four_max: assert property (!f_n [*4] |=> f_n)
    else $error("fast strobe low beyond four clocks");
  a_turnaround_first: assert property ($fell(f_n) |-> !fast_ha_oe && !slow_ha_oe)
    else $error("upper lines driven in turnaround clock");
  a_high_addr_next: assert property ($fell(f_n) ##1 !f_n |-> fast_ha_oe && !slow_ha_oe)
    else $error("fast end not driving high address");
  a_cmd_top_zero: assert property ($fell(f_n) ##1 !f_n [*2] |-> fast_ha_oe && fast_ha_out[15:9] == 7'h00)
    else $error("command word upper bits not zero");
  a_no_contention: assert property (!(fast_ha_oe && slow_ha_oe))
    else $error("both ends drive the upper lines");
  a_slow_one_clock: assert property (!s_n |=> s_n)
    else $error("slow strobe longer than one clock");
  a_slow_drives_ack: assert property (!s_n |-> f_n && slow_ha_oe && shared_host_address_upper == slow_ha_out)
    else $error("slow strobe without slow end data");
  a_low_addr_held: assert property ($changed(host_address_low) |-> $fell(f_n))
    else $error("low address changed outside a cycle start");

  c_commit: cover property (!f_n [*4]);
  c_abort: cover property ($fell(f_n) ##1 f_n);
  c_late_abort: cover property ($fell(f_n) ##1 !f_n [*2] ##1 f_n);
  c_dword: cover property (!s_n ##1 slow_ha_oe);
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce, valid, cpu, wr, dw, irdy, mem, hole, bios, rom, vram, onb, claim, cfg, retry, dma, pwb, dv;
  logic [31:0] addr, wdata, drd, rdata_out, cyc_addr_out, cyc_wdata_out, exp_rd;
  logic [3:0] cmd, be, cyc_cmd_out, cyc_be_out;
  logic req_ready_out, post_allow_out, ahold_out, done_out, abort_out, master_abort_out, busy;
  logic cyc_valid_out, cyc_irdy_dly_out, cyc_write_out, cyc_abort_out, done_ready_out;
  logic [31:0] seed = 32'h4ba9a776;
  logic [73:0] e_cyc, got_cyc;
  logic [73:0] q_cyc[$];
  logic [31:0] q_rd[$];
  logic [1:0] q_ab[$];
  logic [1:0] ab_tab[7] = '{2'b10, 2'b00, 2'b11, 2'b11, 2'b00, 2'b11, 2'b10};
  int n_mismatch = 0;
  int total_checks = 0;
  int n_cab = 0;
  wire logic [15:0] bus = u_fsl_link_if.shared_host_address_upper;

  always #20 clk_in = ~clk_in;

  fsl_link_if u_fsl_link_if ();
  fsl_fast_end u_fsl_fast_end (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce), .req_valid_in(valid),
    .req_ready_out(req_ready_out), .req_cpu_in(cpu), .req_write_in(wr), .req_dword_in(dw), .req_addr_in(addr),
    .req_cmd_in(cmd), .req_be_in(be), .req_wdata_in(wdata), .req_irdy_dly_in(irdy), .req_mem_in(mem),
    .isa_hole_in(hole), .bios_noshadow_in(bios), .rom_cd_in(rom), .vram_ab_fwd_in(vram), .onboard_in(onb),
    .other_claim_in(claim), .cfg_space_in(cfg), .retry_in(retry), .dma_owner_in(dma), .pwb_busy_in(pwb),
    .post_allow_out(post_allow_out), .busy_out(busy), .ahold_out(ahold_out), .done_out(done_out),
    .abort_out(abort_out), .master_abort_out(master_abort_out), .rdata_out(rdata_out), .link(u_fsl_link_if.fast));
  fsl_slow_end u_fsl_slow_end (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce), .cyc_valid_out(cyc_valid_out),
    .cyc_addr_out(cyc_addr_out), .cyc_cmd_out(cyc_cmd_out), .cyc_be_out(cyc_be_out),
    .cyc_irdy_dly_out(cyc_irdy_dly_out), .cyc_wdata_out(cyc_wdata_out), .cyc_write_out(cyc_write_out),
    .cyc_abort_out(cyc_abort_out), .done_valid_in(dv), .done_ready_out(done_ready_out), .done_dword_in(dw),
    .done_rdata_in(drd), .link(u_fsl_link_if.slow));
  fsl_chk u_fsl_chk (.clk_in(clk_in), .rstn_in(rstn_in),
    .fast_start_ready_strobe_n(u_fsl_link_if.fast_start_ready_strobe_n),
    .slow_start_ready_strobe_n(u_fsl_link_if.slow_start_ready_strobe_n),
    .fast_ha_out(u_fsl_link_if.fast_ha_out), .fast_ha_oe(u_fsl_link_if.fast_ha_oe),
    .slow_ha_out(u_fsl_link_if.slow_ha_out), .slow_ha_oe(u_fsl_link_if.slow_ha_oe),
    .host_address_low(u_fsl_link_if.host_address_low), .shared_host_address_upper(bus));

  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [73:0] exp, input logic [73:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (q_cyc.size() + q_rd.size() + q_ab.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic timeout;
    n_mismatch++;
    report_and_stop();
  endtask

  // one link cycle; ab is the expected {abort, master abort}, zero for a committed cycle
  task automatic xfer(input logic w, input logic d, input logic ir, input logic [31:0] a, input logic [1:0] ab);
    logic [15:0] ex[6];
    int n;
    int last;
    @(negedge clk_in);
    seed = lfsr(seed);
    {wr, dw, irdy, addr, wdata, be} = {w, d, ir, a, seed, seed[7:4]};
    cmd = {1'b0, mem, 1'b1, w};
    valid = 1'b1;
    ex = '{16'hffff, a[31:16], {7'h00, ir, cmd, be}, a[15:0], (w && !ir) ? seed[15:0] : 16'hffff, seed[31:16]};
    last = (ab != 2'b00) ? 0 : (w && !ir) ? 5 : 4;
    if (ab != 2'b00) q_ab.push_back(ab);
    else q_cyc.push_back({a, cmd, be, ir, w, (w && !ir) ? seed : 32'h0000_0000});
    for (n = 0; n < 20 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
    if (n == 20) timeout();
    @(negedge clk_in);
    valid = 1'b0;
    check("strobe", 1'b0, u_fsl_link_if.fast_start_ready_strobe_n);
    check("busy", 1'b1, busy);
    for (n = 0; n <= last; n++) begin
      if (n > 0) @(negedge clk_in);
      check("bus", ex[n], bus);
      if (n == 2) check("ahold", cpu & !onb, ahold_out);
    end
    if (ab == 2'b00) begin
      repeat ((w && !ir) ? 2 : 1) @(negedge clk_in);
      check("hold", a[23:2], {bus[7:0], u_fsl_link_if.host_address_low});
    end
    for (n = 0; n < 80 && done_out !== 1'b1 && abort_out !== 1'b1; n++) @(negedge clk_in);
    if (n == 80) timeout();
    check("ahold", 1'b0, ahold_out);
    check("busy", 1'b0, busy);
  endtask

  // isa side answer, prompt or slow, sometimes with the clock enable dropped
  task automatic respond;
    int n;
    seed = lfsr(seed);
    repeat (seed[1:0] + 1) @(negedge clk_in);
    if (seed[2]) begin
      ce = 1'b0;
      repeat (2) @(negedge clk_in);
      ce = 1'b1;
    end
    {dv, drd} = {1'b1, seed};
    if (!wr) exp_rd = dw ? seed : {exp_rd[31:16], seed[15:0]};
    q_rd.push_back(exp_rd);
    // ready is looked at where it is settled, so the coming edge is known to take the completion
    for (n = 0; n < 20 && done_ready_out !== 1'b1; n++) @(negedge clk_in);
    if (n == 20) timeout();
    @(negedge clk_in);
    dv = 1'b0;
  endtask

  always @(negedge clk_in) if (cyc_valid_out === 1'b1) respond();

  always @(negedge clk_in) begin
    if (cyc_valid_out === 1'b1) begin
      e_cyc = q_cyc.size() != 0 ? q_cyc.pop_front() : 'x;
      got_cyc = {cyc_addr_out, cyc_cmd_out, cyc_be_out, cyc_irdy_dly_out, cyc_write_out, cyc_wdata_out};
      if (!(e_cyc[32] && !e_cyc[33])) got_cyc[31:0] = 32'h0000_0000;
      check("cycle", e_cyc, got_cyc);
    end
    if (done_out === 1'b1) check("rdata", q_rd.size() != 0 ? q_rd.pop_front() : 'x, rdata_out);
    if (abort_out === 1'b1) check("abort", q_ab.size() != 0 ? q_ab.pop_front() : 'x, {abort_out, master_abort_out});
    if (cyc_abort_out === 1'b1) n_cab++;
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    {ce, valid, cpu, wr, dw, irdy, hole, bios, rom, vram, onb, claim, cfg, retry, dma, pwb, dv} = '0;
    {addr, wdata, drd, exp_rd, cmd, be} = '0;
    ce = 1'b1;
    mem = 1'b1;
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    {dma, pwb} = 2'b11;
    #1 check("ready", 1'b0, req_ready_out);
    pwb = 1'b0;
    #1 check("ready", 1'b1, req_ready_out);
    dma = 1'b0;
    $display("test gate done");
    cpu = 1'b1;
    for (int i = 0; i < 6; i++) begin
      mem = (i != 1);
      {hole, bios, rom, vram} = {i == 2, i == 3, i == 4, i == 5};
      #1 check("post", i == 0, post_allow_out);
    end
    cpu = 1'b0;
    #1 check("post", 1'b1, post_allow_out);
    {mem, vram} = 2'b10;
    $display("test decode done");
    for (int j = 0; j < 8; j++) begin
      seed = lfsr(seed);
      {cpu, onb, mem} = {j[2], j == 6, !j[1] || j[0]};
      xfer(j[0], j[1], j[0] & j[1], mem ? {8'h00, seed[23:0]} : {16'h0000, seed[15:0]}, 2'b00);
    end
    {cpu, onb} = 2'b00;
    $display("test transfers done");
    for (int k = 0; k < 7; k++) begin
      {claim, cfg, mem, hole, retry} = {k == 0 || k == 1 || k == 6, k == 1, !(k == 2 || k == 6), k == 4, k == 5};
      xfer(1'b0, 1'b0, 1'b0, (k == 2 || k == 6) ? 32'h0001_0000 : (k == 3 || k == 4) ? 32'h0100_0000 : 32'h0000_1000, ab_tab[k]);
    end
    {claim, cfg, hole, retry, mem} = 5'h01;
    // retry raised in the command clock: the strobe stops after three clocks
    fork
      xfer(1'b0, 1'b0, 1'b0, 32'h0000_1000, 2'b11);
      begin
        repeat (4) @(negedge clk_in);
        retry = 1'b1;
      end
    join
    retry = 1'b0;
    repeat (4) @(negedge clk_in);
    check("aborts", 6, n_cab);
    $display("test abort done");
    report_and_stop();
  end
endmodule
